/* File: rtl/lcp_device.sv */
// line unit end of the control port: serial register slave plus control logic
// assumes: control and serial pins are asynchronous to clk and pass two flip-flops first; line status inputs and reset_n are used directly
// Summary of operation
// - equalizer on when bit set or pin low
// - flag transmit lock loss in recovery modes
// - ignore lock loss with parallel interface
// - transmit and receive power down independently
// - power down leaves registers and port alone
// - global pin powers down both transmitters in hardware mode
// - software loop bits select local, remote loop
// - hardware loop pin: low, float remote, high local
// - full digital loop only software, plesiochronous or loop-timed modes
// - power-on reset returns registers to defaults
// - external low reset overrides, never driven high
// - serial port works only while select high
// - enable line starts transfer, acts as select
// - sample on clock rise, launch on fall
// - host sends fields least significant bit first
// - output driven only during read data, lsb first
// - host serial clock at most 20 MHz
// - shared data wire needs tri-state host output
// - each transmitter has own maskable interrupt
// - address byte: rw bit0, sub 3:1, port 7:4
// - port zero global, ports one, two channels
`include "lcp_consts.svh"

module lcp_device
  import lcp_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       reset_pin_n,
  // serial port
  lcp_if.device           sp,
  // hardware control pins
  input  wire lcp_lvl_t   tx_eq_pin,
  input  wire logic       global_tx_powerdown_pin,
  input  wire lcp_lvl_t   loop_select_pin [2],
  // line status per channel
  input  wire logic [1:0] tx_signal_valid,
  input  wire logic [1:0] tx_fifo_error,
  // control outputs per channel
  output logic [1:0]      tx_equalizer_en,
  output logic [1:0]      tx_powerdown,
  output logic [1:0]      rx_powerdown,
  output logic [1:0]      local_loop_en,
  output logic [1:0]      remote_loop_en,
  output logic [1:0]      full_loop_en,
  output logic [1:0]      tx_lock_lost,
  output logic [1:0]      tx_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [5:0] pin_m_q, pin_s_q;
  lcp_lvl_t   eq_m_q, eq_s_q;
  lcp_lvl_t   lp_m_q [2];
  lcp_lvl_t   lp_s_q [2];
  logic       sck_prev_q;
  logic       core_rst;

  // two flops on every asynchronous pin, first flop read only by the second
  always_ff @(posedge clk) begin
    pin_m_q <= {global_tx_powerdown_pin, reset_pin_n, sp.serial_port_select_pin, sp.serial_enable_pin,
                sp.serial_clock_pin, sp.serial_in_pin};
    pin_s_q <= pin_m_q;
    eq_m_q  <= tx_eq_pin;
    eq_s_q  <= eq_m_q;
    lp_m_q  <= loop_select_pin;
    lp_s_q  <= lp_m_q;
    sck_prev_q <= pin_s_q[1];
  end

  wire gpd_s     = pin_s_q[5];
  wire rst_pin_s = pin_s_q[4];
  wire sel_s     = pin_s_q[3];
  wire en_s      = pin_s_q[2];
  wire sck_s     = pin_s_q[1];
  wire sdi_s     = pin_s_q[0];
  wire sck_rise  = sck_s & ~sck_prev_q;
  wire sck_fall  = ~sck_s & sck_prev_q;
  wire port_live = sel_s & en_s;
  wire hw_mode   = ~sel_s;

  // either reset source clears all registers and state
  assign core_rst = ~reset_n | ~rst_pin_s;

  ////////////////////////////////////////////////////////////////////////////
  // serial frame engine
  lcp_dst_t   st_q;
  logic [4:0] cnt_q;
  logic [7:0] addr_q, wdat_q, rsh_q;
  logic       rd_q;
  logic       out_q, oe_q;
  logic       wr_stb;
  logic [7:0] wr_data;
  logic       rd_stb;

  wire [3:0] port_f = addr_q[`LCP_PORT_MSB:`LCP_PORT_LSB];
  wire [2:0] sub_f  = addr_q[`LCP_SUB_MSB:`LCP_SUB_LSB];
  wire [7:0] addr_full = {sdi_s, addr_q[6:0]};

  assign wr_stb  = port_live & sck_rise & (cnt_q == `LCP_FRAME_BITS - 5'h1) & ~rd_q;
  assign wr_data = {sdi_s, wdat_q[6:0]};
  assign rd_stb  = port_live & sck_rise & (cnt_q == 5'h07) & addr_q[`LCP_RW_BIT];

  // bit counter and shift registers, sampled on serial clock rise lsb first
  always_ff @(posedge clk) begin
    if (core_rst || !port_live) begin
      st_q  <= LCP_D_IDLE;
      cnt_q <= 5'h00;
      rd_q  <= 1'b0;
    end else if (sck_rise && cnt_q < `LCP_FRAME_BITS) begin
      cnt_q <= cnt_q + 5'h01;
      case (st_q)
        LCP_D_IDLE: begin
          addr_q[0] <= sdi_s;
          st_q      <= LCP_D_ADDR;
        end
        LCP_D_ADDR: begin
          addr_q[cnt_q[2:0]] <= sdi_s;
          if (cnt_q == 5'h07) begin
            st_q <= LCP_D_DATA;
            rd_q <= addr_q[`LCP_RW_BIT];
          end
        end
        default: wdat_q[cnt_q[2:0]] <= sdi_s;
      endcase
    end
  end

  // read data launched on serial clock fall, driven only while data bits run
  always_ff @(posedge clk) begin
    if (core_rst || !port_live) begin
      oe_q  <= 1'b0;
      out_q <= 1'b0;
    end else if (rd_stb) begin
      rsh_q <= reg_read(addr_full);
    end else if (sck_fall) begin
      if (rd_q && cnt_q >= 5'h08 && cnt_q < `LCP_FRAME_BITS) begin
        oe_q  <= 1'b1;
        out_q <= rsh_q[0];
        rsh_q <= {1'b0, rsh_q[7:1]};
      end else begin
        oe_q <= 1'b0;
      end
    end
  end

  assign sp.serial_out_pin = out_q;
  assign sp.serial_out_oe  = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0] master_q, intctl_q;
  logic [7:0] mode_q [2];
  logic [7:0] sig_q  [2];
  logic [7:0] adv1_q [2];
  logic [7:0] adv0_q [2];
  logic [7:0] mode2_q [2];
  logic [1:0] stat_q [2];
  logic [1:0] lol_now;

  // read mux; unmapped addresses read zero
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    logic [3:0] p;
    logic [2:0] s;
    logic       c;
    p = a[`LCP_PORT_MSB:`LCP_PORT_LSB];
    s = a[`LCP_SUB_MSB:`LCP_SUB_LSB];
    c = (p == `LCP_PORT_CH1);
    reg_read = 8'h00;
    if (p == `LCP_PORT_GLOBAL) begin
      if (s == `LCP_SUB_MASTER) reg_read = master_q;
      else if (s == `LCP_SUB_INTCTL) reg_read = intctl_q;
    end else if (p == `LCP_PORT_CH0 || p == `LCP_PORT_CH1) begin
      if (s == `LCP_SUB_MODE) reg_read = mode_q[c];
      else if (s == `LCP_SUB_SIGNAL) reg_read = sig_q[c];
      else if (s == `LCP_SUB_ADVTX1) reg_read = adv1_q[c];
      else if (s == `LCP_SUB_ADVTX0) reg_read = adv0_q[c];
      else if (s == `LCP_SUB_MODE2) reg_read = mode2_q[c];
      else if (s == `LCP_SUB_STATUS) reg_read = {6'h00, stat_q[c]};
    end
  endfunction : reg_read

  wire soft_rst = master_q[`LCP_SRST_BIT];
  wire wr_glob  = wr_stb & (port_f == `LCP_PORT_GLOBAL);

  // global registers; soft reset bit clears itself after one cycle
  always_ff @(posedge clk) begin
    if (core_rst || soft_rst) begin
      master_q <= `LCP_MASTER_RST;
      intctl_q <= `LCP_INTCTL_RST;
    end else if (wr_glob && sub_f == `LCP_SUB_MASTER) begin
      master_q <= wr_data;
    end else if (wr_glob && sub_f == `LCP_SUB_INTCTL) begin
      intctl_q <= wr_data;
    end
  end

  // per-channel registers; power-down bits never gate these writes
  for (genvar c = 0; c < 2; c++) begin : g_ch
    wire wr_ch = wr_stb & (port_f == 4'(c + 1));
    wire [1:0] smod = mode_q[c][`LCP_SMOD_MSB:`LCP_SMOD_LSB];
    wire cdr_mode   = (smod == `LCP_SMOD_SYNC_D) | (smod == `LCP_SMOD_PLESIO);
    wire clr_stat   = rd_stb & (addr_full[`LCP_PORT_MSB:`LCP_PORT_LSB] == 4'(c + 1))
                      & (addr_full[`LCP_SUB_MSB:`LCP_SUB_LSB] == `LCP_SUB_STATUS);

    // loss of lock only in recovery modes, masked in parallel mode
    assign lol_now[c] = cdr_mode & ~tx_signal_valid[c] & ~master_q[`LCP_PAR_BIT];

    always_ff @(posedge clk) begin
      if (core_rst || soft_rst) begin
        mode_q[c]  <= `LCP_MODE_RST;
        sig_q[c]   <= `LCP_SIGNAL_RST;
        adv1_q[c]  <= `LCP_ADVTX1_RST;
        adv0_q[c]  <= `LCP_ADVTX0_RST;
        mode2_q[c] <= `LCP_MODE2_RST;
      end else if (wr_ch) begin
        if (sub_f == `LCP_SUB_MODE) mode_q[c] <= wr_data;
        else if (sub_f == `LCP_SUB_SIGNAL) sig_q[c] <= wr_data;
        else if (sub_f == `LCP_SUB_ADVTX1) adv1_q[c] <= wr_data;
        else if (sub_f == `LCP_SUB_ADVTX0) adv0_q[c] <= wr_data;
        else if (sub_f == `LCP_SUB_MODE2) mode2_q[c] <= wr_data;
      end
    end

    // sticky status, cleared by reading it; a new event wins over the clear
    always_ff @(posedge clk) begin
      if (core_rst || soft_rst) begin
        stat_q[c] <= 2'h0;
      end else begin
        stat_q[c][`LCP_LOL_BIT]  <= lol_now[c] | (stat_q[c][`LCP_LOL_BIT] & ~clr_stat);
        stat_q[c][`LCP_TX_FIFO_ERROR_BIT] <= tx_fifo_error[c] | (stat_q[c][`LCP_TX_FIFO_ERROR_BIT] & ~clr_stat);
      end
    end

    // registered control outputs
    always_ff @(posedge clk) begin
      if (core_rst) begin
        tx_equalizer_en[c] <= 1'b0;
        tx_powerdown[c]    <= 1'b0;
        rx_powerdown[c]    <= 1'b0;
        local_loop_en[c]   <= 1'b0;
        remote_loop_en[c]  <= 1'b0;
        full_loop_en[c]    <= 1'b0;
        tx_lock_lost[c]    <= 1'b0;
        tx_irq[c]          <= 1'b0;
      end else begin
        tx_equalizer_en[c] <= adv1_q[c][`LCP_TX_EQUALIZER_EN_BIT] | (eq_s_q == LCP_LOW);
        tx_powerdown[c]    <= mode_q[c][`LCP_PDTX_BIT] | (hw_mode & gpd_s);
        rx_powerdown[c]    <= mode_q[c][`LCP_PDRX_BIT];
        if (hw_mode) begin
          local_loop_en[c]  <= (lp_s_q[c] == LCP_HIGH);
          remote_loop_en[c] <= (lp_s_q[c] == LCP_FLOAT);
        end else begin
          local_loop_en[c]  <= sig_q[c][`LCP_LLOOP_BIT];
          remote_loop_en[c] <= sig_q[c][`LCP_RLOOP_BIT];
        end
        full_loop_en[c] <= ~hw_mode & adv0_q[c][`LCP_FLOOP_BIT] & ~master_q[`LCP_PAR_BIT]
                           & ((smod == `LCP_SMOD_PLESIO) | (smod == `LCP_SMOD_LOOPT));
        tx_lock_lost[c] <= lol_now[c];
        // masked event sources, polarity chosen by software
        tx_irq[c] <= intctl_q[`LCP_INPOL_BIT] ~^
                     ((stat_q[c][`LCP_LOL_BIT] & intctl_q[`LCP_MLOL_BIT]) |
                      (stat_q[c][`LCP_TX_FIFO_ERROR_BIT] & intctl_q[`LCP_MFERR_BIT]));
      end
    end
  end

endmodule : lcp_device

/* File: rtl/lcp_consts.svh */
// constants for the line interface control port: address fields, register
// offsets, bit positions, reset values and serial timing counts
// assumes: included by its bare name from the design modules and the testbench
`ifndef LCP_CONSTS_SVH
`define LCP_CONSTS_SVH

// address byte layout, least significant bit first on the wire
`define LCP_RW_BIT        0
`define LCP_SUB_LSB       1
`define LCP_SUB_MSB       3
`define LCP_PORT_LSB      4
`define LCP_PORT_MSB      7
`define LCP_PORT_GLOBAL   4'h0
`define LCP_PORT_CH0      4'h1
`define LCP_PORT_CH1      4'h2
`define LCP_FRAME_BITS    5'h10

// global sub-addresses and fields
`define LCP_SUB_MASTER    3'h0
`define LCP_SUB_INTCTL    3'h1
`define LCP_MASTER_RST    8'h00
`define LCP_INTCTL_RST    8'h23
`define LCP_PAR_BIT       5
`define LCP_SRST_BIT      0
`define LCP_INPOL_BIT     7
`define LCP_MLOL_BIT      1
`define LCP_MFERR_BIT     0

// per-channel sub-addresses and fields
`define LCP_SUB_MODE      3'h0
`define LCP_SUB_SIGNAL    3'h1
`define LCP_SUB_ADVTX1    3'h2
`define LCP_SUB_ADVTX0    3'h3
`define LCP_SUB_MODE2     3'h4
`define LCP_SUB_STATUS    3'h5
`define LCP_MODE_RST      8'h01
`define LCP_SIGNAL_RST    8'h00
`define LCP_ADVTX1_RST    8'h00
`define LCP_ADVTX0_RST    8'hA8
`define LCP_MODE2_RST     8'h80
`define LCP_PDTX_BIT      7
`define LCP_PDRX_BIT      6
`define LCP_SMOD_MSB      4
`define LCP_SMOD_LSB      3
`define LCP_RLOOP_BIT     4
`define LCP_LLOOP_BIT     3
`define LCP_TX_EQUALIZER_EN_BIT      0
`define LCP_FLOOP_BIT     0
`define LCP_LOL_BIT       1
`define LCP_TX_FIFO_ERROR_BIT      0
`define LCP_SMOD_SYNC_D   2'h2
`define LCP_SMOD_PLESIO   2'h1
`define LCP_SMOD_LOOPT    2'h3

// host command port offsets
`define LCP_HREG_ADDR     3'h0
`define LCP_HREG_WDATA    3'h1
`define LCP_HREG_CTRL     3'h2
`define LCP_HREG_STATUS   3'h3
`define LCP_HREG_RDATA    3'h4

// serial clock timing: 20 MHz at most, so each half period is at least 25 ns
`define LCP_CLK_NS        4
`define LCP_SCK_HALF_NS   25
`define LCP_SCK_HALF_CYC  ((`LCP_SCK_HALF_NS + `LCP_CLK_NS - 1) / `LCP_CLK_NS)

`endif

/* File: rtl/lcp_pkg.sv */
// types shared by both ends of the control port
// assumes: lcp_consts.svh sits beside this file
package lcp_pkg;
  // three-level pin reading
  typedef enum logic [1:0] {LCP_LOW, LCP_FLOAT, LCP_HIGH} lcp_lvl_t;
  // device serial port states
  typedef enum logic [1:0] {LCP_D_IDLE, LCP_D_ADDR, LCP_D_DATA} lcp_dst_t;
  // host serial port states
  typedef enum logic [1:0] {LCP_H_IDLE, LCP_H_LEAD, LCP_H_SHIFT, LCP_H_TAIL} lcp_hst_t;
endpackage : lcp_pkg

/* File: rtl/lcp_if.sv */
// four-wire serial register port between a controller and the line unit
// assumes: serial in and out may share a wire; an idle wire reads high
interface lcp_if;
  logic serial_port_select_pin;
  logic serial_enable_pin;
  logic serial_clock_pin;
  logic serial_in_pin;
  logic serial_in_oe;
  logic serial_out_pin;
  logic serial_out_oe;
  logic serial_out_line;

  // resolved level of the data-out wire, pulled high when nobody drives
  assign serial_out_line = serial_out_oe ? serial_out_pin : 1'b1;

  modport device (
    input  serial_port_select_pin, serial_enable_pin, serial_clock_pin, serial_in_pin,
    output serial_out_pin, serial_out_oe
  );
  modport host (
    output serial_port_select_pin, serial_enable_pin, serial_clock_pin, serial_in_pin, serial_in_oe,
    input  serial_out_line
  );
endinterface : lcp_if

/* File: rtl/lcp_host.sv */
// controller end of the control port: turns register-port orders into frames
// assumes: one clk domain; serial clock made here by a divider; sdo is async
`include "lcp_consts.svh"

module lcp_host
  import lcp_pkg::*;
#(
  parameter int unsigned HALF_CYC = `LCP_SCK_HALF_CYC
)(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // command port
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata,
  // serial port
  lcp_if.host             sp
);

  ////////////////////////////////////////////////////////////////////////////
  // command registers
  logic [7:0] cmd_addr_q, cmd_wdata_q, rx_q;
  logic       busy_q, done_q, start;
  logic       finish;

  assign start = wr & (addr == `LCP_HREG_CTRL) & wdata[0] & ~busy_q;

  // software-written address byte and write data
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cmd_addr_q  <= 8'h00;
      cmd_wdata_q <= 8'h00;
    end else if (wr && !busy_q && addr == `LCP_HREG_ADDR) begin
      cmd_addr_q <= wdata;
    end else if (wr && !busy_q && addr == `LCP_HREG_WDATA) begin
      cmd_wdata_q <= wdata;
    end
  end

  // busy level and sticky done; done cleared by a status read, finish wins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      busy_q <= start | (busy_q & ~finish);
      done_q <= finish | (done_q & ~(rd & (addr == `LCP_HREG_STATUS)));
    end
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else if (!rd) begin
      rdata <= 8'h00;
    end else if (addr == `LCP_HREG_ADDR) begin
      rdata <= cmd_addr_q;
    end else if (addr == `LCP_HREG_WDATA) begin
      rdata <= cmd_wdata_q;
    end else if (addr == `LCP_HREG_STATUS) begin
      rdata <= {6'h00, done_q, busy_q};
    end else if (addr == `LCP_HREG_RDATA) begin
      rdata <= rx_q;
    end else begin
      rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial frame generator
  lcp_hst_t   st_q;
  logic [7:0] div_q;
  logic [4:0] bit_q;
  logic [15:0] tx_sh_q;
  logic       sck_q, sen_q, sdi_q, sdi_oe_q, sel_q;
  logic       sdo_m_q, sdo_s_q;
  wire        tick = (div_q == 8'(HALF_CYC - 1));

  assign finish = (st_q == LCP_H_TAIL) & tick;

  // data-out pin passes two flops before sampling
  always_ff @(posedge clk) begin
    sdo_m_q <= sp.serial_out_line;
    sdo_s_q <= sdo_m_q;
  end

  // half-period divider, restarted at every state change
  always_ff @(posedge clk) begin
    if (!reset_n || st_q == LCP_H_IDLE || tick) div_q <= 8'h00;
    else div_q <= div_q + 8'h01;
  end

  // frame: enable, 16 clock periods low then high, enable released
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q     <= LCP_H_IDLE;
      sen_q    <= 1'b0;
      sck_q    <= 1'b0;
      sdi_q    <= 1'b0;
      sdi_oe_q <= 1'b0;
      bit_q    <= 5'h00;
      rx_q     <= 8'h00;
      tx_sh_q  <= 16'h0000;
    end else begin
      case (st_q)
        LCP_H_IDLE: if (start) begin
          st_q    <= LCP_H_LEAD;
          sen_q   <= 1'b1;
          tx_sh_q <= {cmd_wdata_q, cmd_addr_q};
          bit_q   <= 5'h00;
        end
        LCP_H_LEAD: if (tick) begin
          st_q     <= LCP_H_SHIFT;
          sdi_q    <= tx_sh_q[0];
          sdi_oe_q <= 1'b1;
          tx_sh_q  <= {1'b0, tx_sh_q[15:1]};
        end
        LCP_H_SHIFT: if (tick) begin
          if (!sck_q) begin
            sck_q <= 1'b1;
            if (cmd_addr_q[`LCP_RW_BIT] && bit_q >= 5'h08) rx_q <= {sdo_s_q, rx_q[7:1]};
          end else begin
            sck_q <= 1'b0;
            bit_q <= bit_q + 5'h01;
            if (bit_q == `LCP_FRAME_BITS - 5'h1) begin
              st_q     <= LCP_H_TAIL;
              sdi_oe_q <= 1'b0;
            end else begin
              sdi_q    <= tx_sh_q[0];
              // release the data wire while the device answers
              sdi_oe_q <= ~(cmd_addr_q[`LCP_RW_BIT] && bit_q >= 5'h07);
              tx_sh_q  <= {1'b0, tx_sh_q[15:1]};
            end
          end
        end
        default: if (tick) begin
          st_q  <= LCP_H_IDLE;
          sen_q <= 1'b0;
        end
      endcase
    end
  end

  // select held high while out of reset so the port stays usable
  always_ff @(posedge clk) begin
    sel_q <= reset_n;
  end

  assign sp.serial_port_select_pin = sel_q;
  assign sp.serial_enable_pin      = sen_q;
  assign sp.serial_clock_pin       = sck_q;
  assign sp.serial_in_pin          = sdi_q;
  assign sp.serial_in_oe           = sdi_oe_q;

endmodule : lcp_host

/* File: verification/lcp_wire_assertions.sv */
// checker for the serial wire between the controller end and the line unit end
// assumes: instantiated once beside the interface, everything on one clk domain
module lcp_wire_assertions #(
  parameter int unsigned HALF_CYC = 7
)(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // serial wire
  input wire logic serial_port_select_pin,
  input wire logic serial_enable_pin,
  input wire logic serial_clock_pin,
  input wire logic serial_in_pin,
  input wire logic serial_in_oe,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  input wire logic serial_out_line
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic [4:0] bits_q;
  logic [3:0] hi_q;
  logic       rw_q;

  ////////////////////////////////////////////////////////////
  // count clock rises in a frame, keep the direction bit of the first
  always_ff @(posedge clk) begin
    if (!reset_n || !serial_enable_pin) begin
      bits_q <= 5'h00;
    end else if ($rose(serial_clock_pin)) begin
      bits_q <= bits_q + 5'h01;
      if (bits_q == 5'h00) begin
        rw_q <= serial_in_pin;
      end
    end
  end

  // length of the current high phase of the serial clock
  always_ff @(posedge clk) begin
    if (!reset_n || !serial_clock_pin) begin
      hi_q <= 4'h0;
    end else begin
      hi_q <= hi_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////
  a_clk_idle_low: assert property (!serial_enable_pin |-> !serial_clock_pin)
    else $error("serial clock moves outside a frame");
  a_select_held: assert property (serial_enable_pin |-> serial_port_select_pin)
    else $error("frame while port select is low");
  a_clk_high_len: assert property ($fell(serial_clock_pin) |-> hi_q == HALF_CYC)
    else $error("serial clock high phase has wrong length");
  a_sdi_steady: assert property (serial_clock_pin |-> $stable(serial_in_pin))
    else $error("serial input changes while clock is high");
  a_out_on_read: assert property ($rose(serial_out_oe) |-> rw_q && bits_q == 5'h08)
    else $error("data out enabled outside read data phase");
  a_out_off_idle: assert property (!serial_enable_pin [*6] |-> !serial_out_oe)
    else $error("data out still driven after frame end");
  a_out_on_fall: assert property (serial_out_oe && $changed(serial_out_pin) |-> !serial_clock_pin)
    else $error("data out changes while clock is high");
  a_no_fight: assert property (serial_out_oe |-> !serial_in_oe)
    else $error("both ends drive the data wire");
  a_frame_len: assert property ($fell(serial_enable_pin) |-> bits_q == 5'h10)
    else $error("frame does not hold sixteen bits");
endmodule : lcp_wire_assertions

/* File: verification/testbench.sv */
// bench joining controller end and line unit end over the serial interface
// assumes: controller reset low drops port select, giving hardware mode
`include "lcp_consts.svh"

module testbench
  import lcp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, reset_n, host_rst_n, reset_pin_n, wr, rd, gpd;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, rv;
  lcp_lvl_t    eq_pin;
  lcp_lvl_t    loop_pin [2];
  logic [1:0]  sig_valid, fifo_err, eq_en, tx_pd, rx_pd, lloop, rloop, floop, lol, irq;
  int          err_total, check_count;
  // port, sub, reset value of registers read back after reset
  logic [14:0] dtab [5] = '{{4'h0, 3'h1, 8'h23}, {4'h1, 3'h0, 8'h01}, {4'h2, 3'h3, 8'hA8},
                            {4'h2, 3'h4, 8'h80}, {4'h1, 3'h1, 8'h00}};

  lcp_if sp ();
  lcp_host #(.HALF_CYC(7)) u_lcp_host (.clk(clk), .reset_n(host_rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sp(sp.host));
  lcp_device u_lcp_device (.clk(clk), .reset_n(reset_n), .reset_pin_n(reset_pin_n), .sp(sp.device),
    .tx_eq_pin(eq_pin), .global_tx_powerdown_pin(gpd), .loop_select_pin(loop_pin),
    .tx_signal_valid(sig_valid), .tx_fifo_error(fifo_err), .tx_equalizer_en(eq_en),
    .tx_powerdown(tx_pd), .rx_powerdown(rx_pd), .local_loop_en(lloop), .remote_loop_en(rloop),
    .full_loop_en(floop), .tx_lock_lost(lol), .tx_irq(irq));
  lcp_wire_assertions #(.HALF_CYC(7)) u_lcp_wire_assertions (.clk(clk), .reset_n(reset_n),
    .serial_port_select_pin(sp.serial_port_select_pin), .serial_enable_pin(sp.serial_enable_pin),
    .serial_clock_pin(sp.serial_clock_pin), .serial_in_pin(sp.serial_in_pin),
    .serial_in_oe(sp.serial_in_oe), .serial_out_pin(sp.serial_out_pin),
    .serial_out_oe(sp.serial_out_oe), .serial_out_line(sp.serial_out_line));

  // 250 MHz clock
  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr    <= 1'h0;
  endtask : reg_wr

  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd   <= 1'h0;
    @(negedge clk);
    d = rdata;
  endtask : reg_rd

  // one serial frame through the command port, waits on busy with a bound
  task automatic xfer(input logic [3:0] p, input logic [2:0] s, input logic r, input logic [7:0] d,
                      output logic [7:0] q);
    int n;
    logic [7:0] st;
    reg_wr(`LCP_HREG_ADDR, {p, s, r});
    reg_wr(`LCP_HREG_WDATA, d);
    reg_wr(`LCP_HREG_CTRL, 8'h01);
    n = 0;
    do begin
      reg_rd(`LCP_HREG_STATUS, st);
      n++;
    end while (st[0] !== 1'h0 && n < 400);
    chk("frame done", {7'h00, st[0]}, 8'h00);
    reg_rd(`LCP_HREG_RDATA, q);
  endtask : xfer

  task automatic wrx(input logic [3:0] p, input logic [2:0] s, input logic [7:0] d);
    xfer(p, s, 1'h0, d, rv);
  endtask : wrx

  task automatic expect_reg(input string nm, input logic [3:0] p, input logic [2:0] s, input logic [7:0] e);
    xfer(p, s, 1'h1, 8'h00, rv);
    chk(nm, rv, e);
  endtask : expect_reg

  // let level outputs pass the pin synchronisers
  task automatic settle;
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////
  // watchdog against a hung frame
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    $display("Error watchdog expected end seen hang");
    close_out();
  end

  // main sequence
  initial begin
    clk = 1'h0; reset_n = 1'h0; host_rst_n = 1'h0; reset_pin_n = 1'h1; wr = 1'h0; rd = 1'h0;
    addr = 3'h0; wdata = 8'h00; gpd = 1'h0; eq_pin = LCP_FLOAT; loop_pin[0] = LCP_LOW;
    loop_pin[1] = LCP_LOW; sig_valid = 2'h3; fifo_err = 2'h0; err_total = 0; check_count = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'h1;
    host_rst_n <= 1'h1;
    foreach (dtab[i]) expect_reg("default", dtab[i][14:11], dtab[i][10:8], dtab[i][7:0]);
    reg_rd(3'h7, rv);
    chk("cmd gap", rv, 8'h00);
    wrx(4'h3, 3'h0, 8'h55);
    expect_reg("port3", 4'h3, 3'h0, 8'h00);
    $display("defaults done");
    wrx(4'h1, 3'h1, 8'h18);
    wrx(4'h2, 3'h0, 8'hC1);
    settle();
    chk("loops", {4'h0, rloop, lloop}, 8'h05);
    chk("powerdown", {4'h0, tx_pd, rx_pd}, 8'h0A);
    expect_reg("signal kept", 4'h1, 3'h1, 8'h18);
    expect_reg("mode kept", 4'h2, 3'h0, 8'hC1);
    $display("loop and powerdown done");
    wrx(4'h1, 3'h2, 8'h01);
    settle();
    chk("eq bit", eq_en, 8'h01);
    eq_pin <= LCP_LOW;
    settle();
    chk("eq pin", eq_en, 8'h03);
    eq_pin <= LCP_FLOAT;
    wrx(4'h1, 3'h0, 8'h08);
    wrx(4'h1, 3'h3, 8'hA9);
    settle();
    chk("full loop", floop, 8'h01);
    $display("equalizer and full loop done");
    sig_valid <= 2'h2;
    settle();
    chk("lock lost", lol, 8'h01);
    chk("irq lol", irq, 8'h02);
    expect_reg("status lol", 4'h1, 3'h5, 8'h02);
    sig_valid <= 2'h3;
    settle();
    expect_reg("status held", 4'h1, 3'h5, 8'h02);
    expect_reg("status clear", 4'h1, 3'h5, 8'h00);
    chk("irq idle", irq, 8'h03);
    @(posedge clk);
    fifo_err <= 2'h2;
    @(posedge clk);
    fifo_err <= 2'h0;
    settle();
    chk("irq fifo", irq, 8'h01);
    expect_reg("status fifo", 4'h2, 3'h5, 8'h01);
    $display("interrupt done");
    wrx(4'h0, 3'h0, 8'h01);
    expect_reg("soft reset", 4'h2, 3'h0, 8'h01);
    wrx(4'h1, 3'h2, 8'h01);
    host_rst_n <= 1'h0;
    gpd <= 1'h1;
    for (int l = 0; l < 3; l++) begin
      loop_pin[0] <= lcp_lvl_t'(l);
      loop_pin[1] <= lcp_lvl_t'(l);
      settle();
      chk("hw local", lloop, (l == 2) ? 8'h03 : 8'h00);
      chk("hw remote", rloop, (l == 1) ? 8'h03 : 8'h00);
    end
    chk("hw tx pd", tx_pd, 8'h03);
    chk("hw full", floop, 8'h00);
    gpd <= 1'h0;
    host_rst_n <= 1'h1;
    $display("hardware mode done");
    reset_pin_n <= 1'h0;
    repeat (4) @(posedge clk);
    reset_pin_n <= 1'h1;
    repeat (4) @(posedge clk);
    expect_reg("pin reset", 4'h1, 3'h2, 8'h00);
    $display("reset pin done");
    close_out();
  end
endmodule : testbench
